// >>> common/mtrl_pkg.sv
// memory type range lookup: shared constants, register indices and carriers
// assumes one core clock; register selectors are this block's own indices
package mtrl_pkg;
  localparam int ADDR_W = 36;
  localparam int DATA_W = 64;
  localparam int KIND_W = 8;
  localparam int IDX_W = 5;
  localparam int NUM_FIXED = 11;
  localparam int NUM_VAR = 8;
  localparam int FIELDS_PER_REG = 8;
  localparam int PAGE_SHIFT = 12;
  localparam int RANGE_MSB = 35;
  localparam int RANGE_W = RANGE_MSB - PAGE_SHIFT + 1;

  typedef logic [KIND_W-1:0] mtrl_kind_type;
  localparam mtrl_kind_type KIND_UNCACHED = 8'h00;
  localparam mtrl_kind_type KIND_WRITE_COMBINING = 8'h01;
  localparam mtrl_kind_type KIND_WRITE_THROUGH = 8'h04;
  localparam mtrl_kind_type KIND_WRITE_PROTECTED = 8'h05;
  localparam mtrl_kind_type KIND_WRITE_BACK = 8'h06;

  // default_type_control fields
  localparam int FIXED_MAP_ENABLE_BIT = 10;
  localparam int GLOBAL_ENABLE_BIT = 11;
  localparam logic [DATA_W-1:0] DEF_RSVD_MASK = 64'hFFFF_FFFF_FFFF_F300;
  // range_base_and_type / range_mask_and_valid fields
  localparam int RANGE_VALID_BIT = 11;
  localparam logic [DATA_W-1:0] BASE_RSVD_MASK = 64'hFFFF_FFF0_0000_0F00;
  localparam logic [DATA_W-1:0] MASK_RSVD_MASK = 64'hFFFF_FFF0_0000_07FF;
  localparam logic [DATA_W-1:0] REG_RESET = 64'h0000_0000_0000_0000;

  // register selectors
  localparam logic [IDX_W-1:0] IDX_DEFAULT = 5'h00;
  localparam logic [IDX_W-1:0] IDX_FIXED_FIRST = 5'h01;
  localparam logic [IDX_W-1:0] IDX_VAR_FIRST = 5'h10;

  // fixed map geometry inside the first megabyte
  localparam int MEG_BIT = 20;
  localparam int LOW_HALF_BIT = 19;
  localparam int MID_QUARTER_BIT = 18;
  localparam int SLOT_16K = 1;
  localparam int SLOT_4K = 3;

  typedef struct packed {
    logic req;
    logic wr;
    logic [IDX_W-1:0] idx;
    logic [DATA_W-1:0] wdata;
  } mtrl_reg_req_type;

  typedef struct packed {
    logic done;
    logic fault;
    logic [DATA_W-1:0] rdata;
  } mtrl_reg_rsp_type;

  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
  } mtrl_query_type;

  typedef struct packed {
    logic valid;
    mtrl_kind_type kind;
  } mtrl_result_type;

  function automatic logic kind_legal(input mtrl_kind_type k);
    return (k == KIND_UNCACHED) || (k == KIND_WRITE_COMBINING) || (k == KIND_WRITE_THROUGH) ||
           (k == KIND_WRITE_PROTECTED) || (k == KIND_WRITE_BACK);
  endfunction

  function automatic logic fixed_word_legal(input logic [DATA_W-1:0] w);
    logic ok;
    ok = 1'b1;
    for (int b = 0; b < FIELDS_PER_REG; b++) begin
      ok = ok & kind_legal(w[b*KIND_W +: KIND_W]);
    end
    return ok;
  endfunction
endpackage

// >>> core/mtrl_var_match.sv
// memory type range lookup: match of one variable base/mask pair
// assumes registers hold already-checked values
`timescale 1ns/10ps
`default_nettype none
module mtrl_var_match import mtrl_pkg::*; (
  input wire logic [DATA_W-1:0] base_i,
  input wire logic [DATA_W-1:0] mask_i,
  input wire logic [ADDR_W-1:0] addr_i,
  output logic hit_o,
  output mtrl_kind_type kind_o
);
  logic [RANGE_W-1:0] range_base_field;
  logic [RANGE_W-1:0] range_match_mask;

  assign range_base_field = base_i[RANGE_MSB:PAGE_SHIFT];
  assign range_match_mask = mask_i[RANGE_MSB:PAGE_SHIFT];
  // low twelve address bits never take part; cleared mask bits are not compared, so holes widen the match
  assign hit_o = mask_i[RANGE_VALID_BIT] &
                 ((addr_i[RANGE_MSB:PAGE_SHIFT] & range_match_mask) ==
                  (range_base_field & range_match_mask));
  assign kind_o = base_i[KIND_W-1:0];
endmodule
`default_nettype wire

// >>> core/mtrl_range_map.sv
// memory type range lookup: range map registers and per-address type resolution
// assumes register requests come from the model-specific register access path
`timescale 1ns/10ps
`default_nettype none
module mtrl_range_map import mtrl_pkg::*; (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire mtrl_reg_req_type reg_req_i,
  output mtrl_reg_rsp_type reg_rsp_o,
  input wire mtrl_query_type query_i,
  output mtrl_result_type result_o
);
  logic [DATA_W-1:0] default_type_control;
  logic [DATA_W-1:0] fixed_map [NUM_FIXED];
  logic [DATA_W-1:0] range_base_and_type [NUM_VAR];
  logic [DATA_W-1:0] range_mask_and_valid [NUM_VAR];

  logic global_enable;
  logic fixed_map_enable;
  mtrl_kind_type default_kind;

  assign global_enable = default_type_control[GLOBAL_ENABLE_BIT];
  assign fixed_map_enable = default_type_control[FIXED_MAP_ENABLE_BIT];
  assign default_kind = default_type_control[KIND_W-1:0];

  // ---- register access decode
  logic wr_req;
  logic in_fixed;
  logic in_var;
  logic [IDX_W-1:0] fixed_off;
  logic [IDX_W-1:0] var_off;
  logic [2:0] var_pair;
  logic var_is_mask;
  logic next_fault;
  logic wr_ok;
  logic [DATA_W-1:0] next_rdata;

  assign wr_req = reg_req_i.req & reg_req_i.wr;
  assign fixed_off = reg_req_i.idx - IDX_FIXED_FIRST;
  assign var_off = reg_req_i.idx - IDX_VAR_FIRST;
  assign in_fixed = (reg_req_i.idx >= IDX_FIXED_FIRST) &&
                    (fixed_off < IDX_W'(NUM_FIXED));
  assign in_var = (reg_req_i.idx >= IDX_VAR_FIRST);
  assign var_pair = var_off[3:1];
  assign var_is_mask = var_off[0];

  always_comb begin
    next_fault = 1'b0;
    next_rdata = REG_RESET;
    if (reg_req_i.idx == IDX_DEFAULT) begin
      next_rdata = default_type_control;
      // reserved bits and illegal default type both refuse the write
      next_fault = wr_req & (|(reg_req_i.wdata & DEF_RSVD_MASK) |
                   !kind_legal(reg_req_i.wdata[KIND_W-1:0]));
    end else if (in_fixed) begin
      next_rdata = fixed_map[fixed_off[3:0]];
      next_fault = wr_req & !fixed_word_legal(reg_req_i.wdata);
    end else if (in_var && !var_is_mask) begin
      next_rdata = range_base_and_type[var_pair];
      next_fault = wr_req & (|(reg_req_i.wdata & BASE_RSVD_MASK) |
                   !kind_legal(reg_req_i.wdata[KIND_W-1:0]));
    end else if (in_var) begin
      next_rdata = range_mask_and_valid[var_pair];
      next_fault = wr_req & |(reg_req_i.wdata & MASK_RSVD_MASK);
    end else begin
      // unmapped selector faults on read and write alike
      next_fault = reg_req_i.req;
    end
  end

  assign wr_ok = wr_req & !next_fault;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      reg_rsp_o <= '0;
    end else begin
      reg_rsp_o.done <= reg_req_i.req;
      reg_rsp_o.fault <= reg_req_i.req & next_fault;
      reg_rsp_o.rdata <= (reg_req_i.req && !reg_req_i.wr) ? next_rdata : REG_RESET;
    end
  end

  // ---- default type control; reset clears both enables
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      default_type_control <= REG_RESET;
    end else if (wr_ok && reg_req_i.idx == IDX_DEFAULT) begin
      default_type_control <= reg_req_i.wdata;
    end
  end

  // ---- fixed range registers
  genvar gf;
  generate
    for (gf = 0; gf < NUM_FIXED; gf++) begin : g_fixed
      always_ff @(posedge mclk_i) begin
        if (rst_i) begin
          fixed_map[gf] <= REG_RESET;
        end else if (wr_ok && in_fixed && fixed_off == IDX_W'(gf)) begin
          fixed_map[gf] <= reg_req_i.wdata;
        end
      end
    end
  endgenerate

  // ---- variable pairs, all matched in parallel
  logic [NUM_VAR-1:0] var_hit;
  logic [NUM_VAR-1:0] var_valid;
  mtrl_kind_type var_kind [NUM_VAR];

  genvar gv;
  generate
    for (gv = 0; gv < NUM_VAR; gv++) begin : g_var
      always_ff @(posedge mclk_i) begin
        if (rst_i) begin
          range_base_and_type[gv] <= REG_RESET;
        end else if (wr_ok && in_var && !var_is_mask && var_pair == 3'(gv)) begin
          range_base_and_type[gv] <= reg_req_i.wdata;
        end
      end

      always_ff @(posedge mclk_i) begin
        if (rst_i) begin
          range_mask_and_valid[gv] <= REG_RESET;
        end else if (wr_ok && in_var && var_is_mask && var_pair == 3'(gv)) begin
          range_mask_and_valid[gv] <= reg_req_i.wdata;
        end
      end

      assign var_valid[gv] = range_mask_and_valid[gv][RANGE_VALID_BIT];

      mtrl_var_match u_match (
        .base_i(range_base_and_type[gv]),
        .mask_i(range_mask_and_valid[gv]),
        .addr_i(query_i.addr),
        .hit_o(var_hit[gv]),
        .kind_o(var_kind[gv])
      );
    end
  endgenerate

  // ---- fixed lookup
  logic in_first_meg;
  logic fixed_active;
  logic [3:0] fixed_sel;
  logic [2:0] fixed_byte;
  mtrl_kind_type fixed_kind;

  assign in_first_meg = ~|query_i.addr[ADDR_W-1:MEG_BIT];
  assign fixed_active = global_enable & fixed_map_enable & in_first_meg;

  always_comb begin
    if (!query_i.addr[LOW_HALF_BIT]) begin
      fixed_sel = 4'h0;
      fixed_byte = query_i.addr[18:16];
    end else if (!query_i.addr[MID_QUARTER_BIT]) begin
      fixed_sel = 4'(SLOT_16K) + {3'h0, query_i.addr[17]};
      fixed_byte = query_i.addr[16:14];
    end else begin
      fixed_sel = 4'(SLOT_4K) + {1'h0, query_i.addr[17:15]};
      fixed_byte = query_i.addr[14:12];
    end
  end

  assign fixed_kind = fixed_map[fixed_sel][fixed_byte*KIND_W +: KIND_W];

  // ---- variable overlap resolution
  logic any_var;
  logic var_has_uncached;
  logic var_has_write_through;
  mtrl_kind_type var_first;

  always_comb begin
    var_has_uncached = 1'b0;
    var_has_write_through = 1'b0;
    var_first = KIND_UNCACHED;
    for (int i = NUM_VAR - 1; i >= 0; i--) begin
      if (var_hit[i]) begin
        var_first = var_kind[i];
        var_has_uncached = var_has_uncached | (var_kind[i] == KIND_UNCACHED);
        var_has_write_through = var_has_write_through | (var_kind[i] == KIND_WRITE_THROUGH);
      end
    end
  end

  assign any_var = |var_hit;

  // ---- final type; undefined overlaps take the lowest matching pair
  mtrl_kind_type next_kind;

  always_comb begin
    if (!global_enable) begin
      next_kind = KIND_UNCACHED;
    end else if (fixed_active) begin
      next_kind = fixed_kind;
    end else if (any_var && var_has_uncached) begin
      next_kind = KIND_UNCACHED;
    end else if (any_var && var_has_write_through) begin
      next_kind = KIND_WRITE_THROUGH;
    end else if (any_var) begin
      next_kind = var_first;
    end else begin
      next_kind = default_kind;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      result_o <= '0;
    end else begin
      result_o.valid <= query_i.valid;
      result_o.kind <= query_i.valid ? next_kind : KIND_UNCACHED;
    end
  end

  // ---- checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  disabled_uncached_a: assert property (
    query_i.valid && !global_enable |=> result_o.valid && result_o.kind == KIND_UNCACHED)
    else $error("map disabled but type not uncached");

  fixed_enable_ignored_a: assert property (
    query_i.valid && !global_enable && fixed_map_enable && in_first_meg
    |=> result_o.kind == KIND_UNCACHED)
    else $error("fixed enable acted while map disabled");

  default_kind_a: assert property (
    query_i.valid && global_enable && !fixed_active && !any_var
    |=> result_o.kind == $past(default_kind))
    else $error("uncovered address did not get default type");

  fixed_override_a: assert property (
    query_i.valid && fixed_active |=> result_o.kind == $past(fixed_kind))
    else $error("fixed field did not override");

  var_uncached_wins_a: assert property (
    query_i.valid && global_enable && !fixed_active && var_has_uncached
    |=> result_o.kind == KIND_UNCACHED)
    else $error("uncached overlap not resolved to uncached");

  pair_invalid_a: assert property (
    (var_hit & ~var_valid) == '0)
    else $error("invalid pair matched");

  default_rsvd_fault_a: assert property (
    wr_req && reg_req_i.idx == IDX_DEFAULT && |(reg_req_i.wdata & DEF_RSVD_MASK)
    |=> reg_rsp_o.fault && $stable(default_type_control))
    else $error("reserved default bits accepted");

  default_kind_fault_a: assert property (
    wr_req && reg_req_i.idx == IDX_DEFAULT && !kind_legal(reg_req_i.wdata[KIND_W-1:0])
    |=> reg_rsp_o.fault ##0 default_type_control == $past(default_type_control))
    else $error("illegal default type accepted");

  var_rsvd_fault_a: assert property (
    wr_req && in_var && var_is_mask && |(reg_req_i.wdata & MASK_RSVD_MASK)
    |=> reg_rsp_o.done && reg_rsp_o.fault)
    else $error("reserved mask bits accepted");
endmodule
`default_nettype wire

// >>> sim/mtrl_query_host.sv
// partner: memory access path that issues type queries and latches answers
// assumes go_i changes away from the rising edge
`timescale 1ns/10ps
`default_nettype none
module mtrl_query_host import mtrl_pkg::*; (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire logic [ADDR_W-1:0] addr_i,
  output var mtrl_query_type query_o,
  input wire mtrl_result_type result_i,
  output var logic seen_o,
  output var mtrl_kind_type kind_o
);
  // idle address flips each cycle so a stale one is never mistaken for a query
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      query_o <= '0;
    end else begin
      query_o.valid <= go_i;
      query_o.addr <= go_i ? addr_i : ~query_o.addr;
    end
  end
  always_ff @(posedge mclk_i) begin
    seen_o <= result_i.valid;
    kind_o <= result_i.kind;
  end
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
// bench: register accesses and type queries with expected results
// assumes the query partner model and the range map package
`timescale 1ns/10ps
`default_nettype none
module tb_top import mtrl_pkg::*;;
  localparam logic [DATA_W-1:0] FIX_WORD = 64'h0001_0405_0604_0100;
  localparam logic [DATA_W-1:0] MASK_64M = 64'h0000_000F_FC00_0800;
  localparam logic [DATA_W-1:0] MASK_32M = 64'h0000_000F_FE00_0800;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  mtrl_reg_req_type reg_req = '0;
  mtrl_reg_rsp_type reg_rsp;
  mtrl_query_type query;
  mtrl_result_type result;
  logic go = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic seen;
  mtrl_kind_type kind;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [IDX_W-1:0] fix_idx [3] = '{5'h01, 5'h03, 5'h0B};
  logic [ADDR_W-1:0] fix_base [3] = '{36'h0_0000_0000, 36'h0_000A_0000, 36'h0_000F_8000};
  logic [ADDR_W-1:0] fix_step [3] = '{36'h0_0001_0000, 36'h0_0000_4000, 36'h0_0000_1000};

  always #20 mclk_i = ~mclk_i;

  mtrl_range_map dut (.mclk_i(mclk_i), .rst_i(rst_i), .reg_req_i(reg_req), .reg_rsp_o(reg_rsp),
    .query_i(query), .result_o(result));
  mtrl_query_host host (.mclk_i(mclk_i), .rst_i(rst_i), .go_i(go), .addr_i(addr), .query_o(query),
    .result_i(result), .seen_o(seen), .kind_o(kind));

  task automatic stop_test;
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk_word(input string name, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  task automatic chk_kind(input string name, input mtrl_kind_type exp, input mtrl_kind_type got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  // response is registered on the taking edge itself, so it is read at the next falling edge
  task automatic reg_op(input logic wr, input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] data,
                        input logic fault, input logic [DATA_W-1:0] rexp);
    @(negedge mclk_i);
    reg_req = '{req: 1'b1, wr: wr, idx: idx, wdata: data};
    @(negedge mclk_i);
    reg_req.req = 1'b0;
    chk_word("done and fault", {62'h0, 1'b1, fault}, {62'h0, reg_rsp.done, reg_rsp.fault});
    chk_word("read data", rexp, reg_rsp.rdata);
  endtask

  task automatic ask(input logic [ADDR_W-1:0] a, input mtrl_kind_type exp);
    int i;
    @(negedge mclk_i);
    go = 1'b1;
    addr = a;
    @(negedge mclk_i);
    go = 1'b0;
    for (i = 0; i < 6 && seen !== 1'b1; i++) @(negedge mclk_i);
    chk_kind("answer strobe", 8'h01, {7'h00, seen});
    chk_kind("memory kind", exp, kind);
  endtask

  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      stop_test();
    end
  end

  initial begin
    repeat (16) @(negedge mclk_i);
    rst_i = 1'b0;
    ask(36'h0_0000_1000, KIND_UNCACHED);
    reg_op(1'b0, IDX_DEFAULT, '0, 1'b0, REG_RESET);
    reg_op(1'b1, IDX_VAR_FIRST, 64'h6, 1'b0, '0);
    reg_op(1'b1, IDX_VAR_FIRST + 5'h01, MASK_64M, 1'b0, '0);
    ask(36'h0_0200_0000, KIND_UNCACHED);
    reg_op(1'b1, IDX_DEFAULT, 64'h805, 1'b0, '0);
    ask(36'h0_0200_0000, KIND_WRITE_BACK);
    ask(36'h0_0000_1000, KIND_WRITE_BACK);
    ask(36'h0_0400_0000, KIND_WRITE_PROTECTED);
    ask(36'h8_0000_0000, KIND_WRITE_PROTECTED);
    for (int t = 0; t < 3; t++) reg_op(1'b1, fix_idx[t], FIX_WORD, 1'b0, '0);
    reg_op(1'b1, IDX_DEFAULT, 64'hC05, 1'b0, '0);
    // top byte of each piece catches an off-by-one in the slot decode
    for (int t = 0; t < 3; t++) begin
      for (int b = 0; b < 8; b++) begin
        ask(fix_base[t] + b * fix_step[t] + fix_step[t] - 1, FIX_WORD[b*8 +: 8]);
      end
    end
    ask(36'h0_0008_0000, KIND_UNCACHED);
    ask(36'h0_0010_0000, KIND_WRITE_BACK);
    reg_op(1'b1, IDX_DEFAULT, 64'hD05, 1'b1, '0);
    reg_op(1'b1, IDX_DEFAULT, 64'h100_0C05, 1'b1, '0);
    reg_op(1'b1, IDX_DEFAULT, 64'hC02, 1'b1, '0);
    reg_op(1'b1, IDX_DEFAULT, 64'hC07, 1'b1, '0);
    reg_op(1'b0, IDX_DEFAULT, '0, 1'b0, 64'hC05);
    reg_op(1'b1, 5'h01, 64'h3, 1'b1, '0);
    reg_op(1'b0, 5'h01, '0, 1'b0, FIX_WORD);
    reg_op(1'b1, IDX_VAR_FIRST, 64'h106, 1'b1, '0);
    reg_op(1'b1, IDX_VAR_FIRST + 5'h01, MASK_64M | 64'h1, 1'b1, '0);
    reg_op(1'b0, 5'h0C, '0, 1'b1, '0);
    reg_op(1'b1, IDX_VAR_FIRST + 5'h02, 64'h0200_0000, 1'b0, '0);
    reg_op(1'b1, IDX_VAR_FIRST + 5'h03, MASK_32M, 1'b0, '0);
    ask(36'h0_0200_0000, KIND_UNCACHED);
    ask(36'h0_0100_0000, KIND_WRITE_BACK);
    reg_op(1'b1, IDX_VAR_FIRST + 5'h03, MASK_32M & ~64'h800, 1'b0, '0);
    ask(36'h0_0200_0000, KIND_WRITE_BACK);
    reg_op(1'b1, IDX_VAR_FIRST + 5'h04, 64'h1000_0004, 1'b0, '0);
    reg_op(1'b1, IDX_VAR_FIRST + 5'h05, 64'h0000_000F_FFFF_D800, 1'b0, '0);
    ask(36'h0_1000_2000, KIND_WRITE_THROUGH);
    ask(36'h0_1000_1000, KIND_WRITE_PROTECTED);
    reg_op(1'b1, IDX_DEFAULT, 64'h406, 1'b0, '0);
    ask(36'h0_0000_0000, KIND_UNCACHED);
    ask(36'h0_0200_0000, KIND_UNCACHED);
    // uncached default keeps unpopulated space safe; write-through beats write-back on overlap
    reg_op(1'b1, IDX_DEFAULT, 64'h800, 1'b0, '0);
    reg_op(1'b1, IDX_VAR_FIRST + 5'h06, 64'h4, 1'b0, '0);
    reg_op(1'b1, IDX_VAR_FIRST + 5'h07, 64'h0000_000F_FFFF_F800, 1'b0, '0);
    ask(36'h0_0000_0800, KIND_WRITE_THROUGH);
    ask(36'h8_0000_0000, KIND_UNCACHED);
    stop_test();
  end
endmodule
`default_nettype wire
